// *** pms_pkg.sv ***
// Shared constants and types for the power-mode sequencer.
package pms_pkg;

    // Clock source select encodings.
    localparam logic [1:0] SRC_PRIMARY   = 2'h0;
    localparam logic [1:0] SRC_SECONDARY = 2'h1;
    localparam int         SRC_UPPER_BIT = 1;

    // Timing, in nanoseconds and in cycles of the 40 ns clock.
    localparam int CLK_PERIOD_NS        = 40;
    localparam int WAKE_PREP_NS         = 2000;
    localparam int INTERNAL_FAST_OSC_SETTLE_NS     = 4000;
    localparam int WAKE_PREP_CYCLES     =
        (WAKE_PREP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INTERNAL_FAST_OSC_SETTLE_CYCLES =
        (INTERNAL_FAST_OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Reset values of the oscillator control fields.
    localparam logic [2:0] FREQ_SELECT_RESET = 3'h0;
    localparam logic [1:0] SOURCE_RESET      = 2'h0;

    typedef enum logic [4:0] {
        ST_STARTUP = 5'h01,
        ST_RUN     = 5'h02,
        ST_IDLE    = 5'h04,
        ST_SLEEP   = 5'h08,
        ST_WAKE    = 5'h10
    } mode_state_type;

    // Oscillator control as software writes it.
    typedef struct packed {
        logic       idle_on_sleep;
        logic [2:0] internal_fast_osc_freq_select;
        logic       low_freq_source_select;
        logic [1:0] clock_source_select;
    } osc_control_type;

    // Readiness reported by the oscillators.
    typedef struct packed {
        logic primary_ready;
        logic secondary_ready;
        logic internal_fast_osc_ready;
    } osc_ready_type;

endpackage : pms_pkg

// *** settle_timer.sv ***
// Counter that reports when an enable has stood for a number of cycles.
`timescale 1ns/1ps
module settle_timer #(
    parameter int COUNT = 1
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Control
    input  wire logic enable,
    output logic      done
);
    localparam int W = $clog2(COUNT + 1) + 1;
    localparam logic [W-1:0] LAST = W'(COUNT);

    logic [W-1:0] count_reg;

    always_ff @(posedge mclk)
    begin
        if (rst || !enable)
            count_reg <= '0;
        else if (count_reg != LAST)
            count_reg <= count_reg + W'(1);
    end

    assign done = enable && (count_reg == LAST);

endmodule : settle_timer

// *** clock_select_glitchfree.sv ***
// Glitch-free choice of the active clock source with ready hand-off.
`timescale 1ns/1ps
module clock_select_glitchfree (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // Request
    input  wire logic [1:0]             requested_source,
    input  wire pms_pkg::osc_ready_type ready,
    // Result
    output logic [1:0]                  active_source,
    output logic                        switch_pulse
);
    logic [1:0] active_reg;
    logic       target_ready;

    always_comb
    begin
        if (requested_source[pms_pkg::SRC_UPPER_BIT])
            target_ready = ready.internal_fast_osc_ready;
        else if (requested_source == pms_pkg::SRC_SECONDARY)
            target_ready = ready.secondary_ready;
        else
            target_ready = ready.primary_ready;
    end

    // The old source stays in use until the new one is ready.
    always_ff @(posedge mclk)
    begin
        if (rst)
            active_reg <= pms_pkg::SOURCE_RESET;
        else if (requested_source != active_reg && target_ready)
            active_reg <= requested_source;
    end

    assign switch_pulse = (requested_source != active_reg) && target_ready;
    assign active_source = active_reg;

endmodule : clock_select_glitchfree

// *** power_mode_sequencer.sv ***
// Power-managed mode sequencer: run, idle, sleep entry and wake exit.
`timescale 1ns/1ps
module power_mode_sequencer #(
    parameter int WAKE_PREP_CYCLES     = pms_pkg::WAKE_PREP_CYCLES,
    parameter int INTERNAL_FAST_OSC_SETTLE_CYCLES = pms_pkg::INTERNAL_FAST_OSC_SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst,
    // Software control
    input  wire logic                     osc_control_write,
    input  wire pms_pkg::osc_control_type osc_control_wdata,
    output pms_pkg::osc_control_type      osc_control_reg,
    // CPU instructions
    input  wire logic                     sleep_instr,
    input  wire logic                     watchdog_clear_instr,
    // Interrupt sources
    input  wire logic [7:0]               irq_flags,
    input  wire logic [7:0]               irq_enables,
    input  wire logic                     global_irq_enable,
    // Watchdog and clock monitor
    input  wire logic                     watchdog_enable,
    input  wire logic                     watchdog_timeout,
    input  wire logic                     failsafe_enable,
    input  wire logic                     clock_lost,
    // Oscillator status
    input  wire pms_pkg::osc_ready_type   osc_ready,
    // Clock gating and oscillator enables
    output logic                          cpu_clock_on,
    output logic                          periph_clock_on,
    output logic [1:0]                    active_source,
    output logic                          primary_osc_on,
    output logic                          internal_fast_osc_on,
    output logic                          internal_slow_osc_on,
    // Status flags
    output logic                          primary_ready_flag,
    output logic                          internal_fast_osc_stable_flag,
    // CPU and watchdog actions
    output logic                          cpu_hold,
    output logic                          take_irq_vector,
    output logic                          watchdog_reset,
    output logic                          watchdog_clear,
    output pms_pkg::mode_state_type       mode
);
    localparam int WW = $clog2(WAKE_PREP_CYCLES + 1) + 1;
    localparam logic [WW-1:0] WAKE_LAST = WW'(WAKE_PREP_CYCLES);

    pms_pkg::mode_state_type state_reg;
    pms_pkg::osc_control_type ctrl_reg;
    logic [WW-1:0] wake_count_reg;
    logic          wake_by_irq_reg;
    logic          vector_reg;
    logic          wdt_reset_reg;
    logic          wdt_clear_reg;
    logic          prim_ready_reg;
    logic          prim_on_reg;
    logic          irq_pending;
    logic          wake_event;
    logic          low_power;
    logic          internal_fast_osc_request;
    logic          internal_fast_osc_done;
    logic          switch_pulse;
    logic          freq_write;

    // A source only counts when both its flag and its enable are set.
    assign irq_pending = |(irq_flags & irq_enables);
    assign low_power = (state_reg == pms_pkg::ST_IDLE)
                    || (state_reg == pms_pkg::ST_SLEEP);
    assign wake_event = low_power
                     && (irq_pending || watchdog_timeout);
    assign freq_write = osc_control_write
        && osc_control_wdata.internal_fast_osc_freq_select
           != ctrl_reg.internal_fast_osc_freq_select;

    clock_select_glitchfree u_select (
        .mclk             (mclk),
        .rst              (rst),
        .requested_source (ctrl_reg.clock_source_select),
        .ready            (osc_ready),
        .active_source    (active_source),
        .switch_pulse     (switch_pulse)
    );

    // Fast oscillator enable follows the frequency select and the low-frequency source bit.
    assign internal_fast_osc_request = (ctrl_reg.internal_fast_osc_freq_select != 3'h0)
                         || ctrl_reg.low_freq_source_select;

    settle_timer #(
        .COUNT (INTERNAL_FAST_OSC_SETTLE_CYCLES)
    ) u_settle (
        .mclk   (mclk),
        .rst    (rst),
        .enable (internal_fast_osc_request && osc_ready.internal_fast_osc_ready),
        .done   (internal_fast_osc_done)
    );

    // Control bits change only by software; wake leaves them alone.
    always_ff @(posedge mclk)
    begin
        if (rst)
            ctrl_reg <= '{idle_on_sleep:          1'b0,
                          internal_fast_osc_freq_select:     pms_pkg::FREQ_SELECT_RESET,
                          low_freq_source_select: 1'b0,
                          clock_source_select:    pms_pkg::SOURCE_RESET};
        else if (osc_control_write)
            ctrl_reg <= osc_control_wdata;
    end

    // Mode sequencing.
    always_ff @(posedge mclk)
    begin
        if (rst)
            state_reg <= pms_pkg::ST_STARTUP;
        else
        begin
            case (state_reg)
                pms_pkg::ST_STARTUP:
                    if (ctrl_reg.clock_source_select[pms_pkg::SRC_UPPER_BIT]
                        || osc_ready.primary_ready)
                        state_reg <= pms_pkg::ST_RUN;
                pms_pkg::ST_RUN:
                    if (sleep_instr)
                        state_reg <= ctrl_reg.idle_on_sleep
                            ? pms_pkg::ST_IDLE
                            : pms_pkg::ST_SLEEP;
                pms_pkg::ST_IDLE, pms_pkg::ST_SLEEP:
                    if (wake_event)
                        state_reg <= pms_pkg::ST_WAKE;
                pms_pkg::ST_WAKE:
                    if (wake_count_reg == WAKE_LAST)
                        state_reg <= pms_pkg::ST_RUN;
                default:
                    state_reg <= pms_pkg::ST_STARTUP;
            endcase
        end
    end

    // Wake preparation delay counter.
    always_ff @(posedge mclk)
    begin
        if (rst || state_reg != pms_pkg::ST_WAKE)
            wake_count_reg <= '0;
        else if (wake_count_reg != WAKE_LAST)
            wake_count_reg <= wake_count_reg + WW'(1);
    end

    // Remember the wake cause so the vector decision is made at resume.
    always_ff @(posedge mclk)
    begin
        if (rst)
            wake_by_irq_reg <= 1'b0;
        else if (wake_event)
            wake_by_irq_reg <= irq_pending;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            vector_reg <= 1'b0;
        else
            vector_reg <= (state_reg == pms_pkg::ST_WAKE)
                && (wake_count_reg == WAKE_LAST)
                && wake_by_irq_reg && global_irq_enable;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            wdt_reset_reg <= 1'b0;
        else
            wdt_reset_reg <= (state_reg == pms_pkg::ST_RUN)
                && watchdog_timeout;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            wdt_clear_reg <= 1'b0;
        else
            wdt_clear_reg <= (sleep_instr && state_reg == pms_pkg::ST_RUN)
                || watchdog_clear_instr
                || (failsafe_enable && clock_lost)
                || (freq_write && active_source[pms_pkg::SRC_UPPER_BIT]);
    end

    // The primary oscillator is stopped once the internal source is in use.
    always_ff @(posedge mclk)
    begin
        if (rst)
            prim_on_reg <= 1'b1;
        else if (switch_pulse)
            prim_on_reg <= !ctrl_reg.clock_source_select[
                               pms_pkg::SRC_UPPER_BIT];
    end

    // The ready flag sets from the oscillator and clears on internal switch.
    always_ff @(posedge mclk)
    begin
        if (rst)
            prim_ready_reg <= 1'b0;
        else if (switch_pulse
                 && ctrl_reg.clock_source_select[pms_pkg::SRC_UPPER_BIT])
            prim_ready_reg <= 1'b0;
        else if (prim_on_reg && osc_ready.primary_ready
                 && active_source == pms_pkg::SRC_PRIMARY)
            prim_ready_reg <= 1'b1;
    end

    // Gated clocks: peripherals run in Idle even while settling.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cpu_clock_on    <= 1'b0;
            periph_clock_on <= 1'b0;
        end
        else
        begin
            cpu_clock_on    <= (state_reg == pms_pkg::ST_RUN);
            periph_clock_on <= (state_reg != pms_pkg::ST_SLEEP)
                && (state_reg != pms_pkg::ST_STARTUP);
        end
    end

    // The stable flag follows the settle timer, so it survives sleep.
    always_ff @(posedge mclk)
    begin
        if (rst)
            internal_fast_osc_stable_flag <= 1'b0;
        else
            internal_fast_osc_stable_flag <= internal_fast_osc_done;
    end

    // Nothing but the slow oscillator for the watchdog or fail-safe runs in Sleep.
    assign internal_fast_osc_on = internal_fast_osc_request
        && state_reg != pms_pkg::ST_SLEEP;
    assign internal_slow_osc_on = watchdog_enable || failsafe_enable
        || (active_source[pms_pkg::SRC_UPPER_BIT]
            && state_reg != pms_pkg::ST_SLEEP);
    assign primary_osc_on     = prim_on_reg
        && state_reg != pms_pkg::ST_SLEEP;
    assign primary_ready_flag = prim_ready_reg;
    assign osc_control_reg    = ctrl_reg;
    assign cpu_hold           = state_reg != pms_pkg::ST_RUN;
    assign take_irq_vector    = vector_reg;
    assign watchdog_reset     = wdt_reset_reg;
    assign watchdog_clear     = wdt_clear_reg;
    assign mode               = state_reg;

endmodule : power_mode_sequencer

// *** pms_monitor.sv ***
// Port-level assertions for the power-mode sequencer.
`timescale 1ns/1ps
module pms_monitor #(
    parameter int WAKE_PREP_CYCLES = 1
) (
    // Clock and reset
    input wire logic                     mclk,
    input wire logic                     rst,
    // Inputs of the sequencer
    input wire logic                     osc_control_write,
    input wire logic                     sleep_instr,
    input wire logic [7:0]               irq_flags,
    input wire logic [7:0]               irq_enables,
    input wire logic                     watchdog_enable,
    input wire logic                     watchdog_timeout,
    // Outputs of the sequencer
    input wire pms_pkg::osc_control_type osc_control_reg,
    input wire logic                     cpu_clock_on,
    input wire logic                     periph_clock_on,
    input wire logic                     internal_slow_osc_on,
    input wire logic                     watchdog_reset,
    input wire logic                     watchdog_clear,
    input wire pms_pkg::mode_state_type  mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Cycles spent in the wake state so far; the delay is a parameter.
    int wake_cnt;
    always_ff @(posedge mclk)
    begin
        if (rst || mode != pms_pkg::ST_WAKE)
            wake_cnt <= 0;
        else
            wake_cnt <= wake_cnt + 1;
    end

    a_enter_idle: assert property (
        mode == pms_pkg::ST_RUN && sleep_instr && osc_control_reg.idle_on_sleep
        |=> mode == pms_pkg::ST_IDLE) else $error("idle entry missed");
    a_enter_sleep: assert property (
        mode == pms_pkg::ST_RUN && sleep_instr && !osc_control_reg.idle_on_sleep
        |=> mode == pms_pkg::ST_SLEEP) else $error("sleep entry missed");
    a_sleep_dark: assert property (
        mode == pms_pkg::ST_SLEEP ##1 mode == pms_pkg::ST_SLEEP
        |-> !cpu_clock_on && !periph_clock_on) else $error("clock in sleep");
    a_idle_clocks: assert property (
        mode == pms_pkg::ST_IDLE ##1 mode == pms_pkg::ST_IDLE
        |-> periph_clock_on && !cpu_clock_on) else $error("idle clocks wrong");
    a_wake_start: assert property (
        (mode == pms_pkg::ST_IDLE || mode == pms_pkg::ST_SLEEP)
        && ((irq_flags & irq_enables) != 8'h00 || watchdog_timeout)
        |=> mode == pms_pkg::ST_WAKE) else $error("wake not started");
    a_wake_hold: assert property (
        mode == pms_pkg::ST_WAKE && wake_cnt < WAKE_PREP_CYCLES
        |=> mode == pms_pkg::ST_WAKE) else $error("wake delay cut short");
    a_wake_end: assert property (
        mode == pms_pkg::ST_WAKE && wake_cnt == WAKE_PREP_CYCLES
        |=> mode == pms_pkg::ST_RUN) else $error("wake delay overrun");
    a_run_wdt: assert property (
        mode == pms_pkg::ST_RUN && watchdog_timeout
        |=> watchdog_reset) else $error("no watchdog reset");
    a_sleep_clear: assert property (
        mode == pms_pkg::ST_RUN && sleep_instr
        |=> watchdog_clear) else $error("no watchdog clear");
    a_ctrl_kept: assert property (
        mode != pms_pkg::ST_RUN && !osc_control_write
        |=> $stable(osc_control_reg)) else $error("control changed");
    a_slow_idle: assert property (
        mode == pms_pkg::ST_IDLE && watchdog_enable
        |-> internal_slow_osc_on) else $error("slow osc stopped");
endmodule : pms_monitor

// *** pms_partner.sv ***
// Model of the interrupt sources and watchdog facing the sequencer.
`timescale 1ns/1ps
module pms_partner (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Requests from the bench and core state
    input  wire logic [7:0] irq_req,
    input  wire logic       wdt_req,
    input  wire logic       cpu_hold,
    // Toward the sequencer
    output logic [7:0]      irq_flags,
    output logic            watchdog_timeout
);
    // Flags persist until the core runs, since only a handler clears them.
    always_ff @(posedge mclk)
    begin
        if (rst)
            irq_flags <= 8'h00;
        else if (irq_req != 8'h00)
            irq_flags <= irq_flags | irq_req;
        else if (!cpu_hold)
            irq_flags <= 8'h00;
        watchdog_timeout <= !rst && wdt_req;
    end
endmodule : pms_partner

// *** test_power_mode_sequencer.sv ***
// Self-checking testbench for the power-mode sequencer.
`timescale 1ns/1ps
module test_power_mode_sequencer;
    localparam int WAKE = 3;
    logic                     mclk = 1'b0;
    logic                     rst = 1'b1;
    logic                     osc_control_write = 1'b0;
    pms_pkg::osc_control_type osc_control_wdata = '0;
    logic                     sleep_instr = 1'b0;
    logic                     watchdog_clear_instr = 1'b0;
    logic [7:0]               irq_req = 8'h00;
    logic [7:0]               irq_enables = 8'h00;
    logic                     global_irq_enable = 1'b0;
    logic                     watchdog_enable = 1'b0;
    logic                     wdt_req = 1'b0;
    pms_pkg::osc_ready_type   osc_ready = 3'h4;
    pms_pkg::osc_control_type osc_control_reg;
    pms_pkg::mode_state_type  mode;
    logic [7:0]               irq_flags;
    logic [1:0]               active_source;
    logic                     watchdog_timeout, cpu_clock_on, periph_clock_on;
    logic                     primary_osc_on, internal_fast_osc_on;
    logic                     internal_slow_osc_on, primary_ready_flag;
    logic                     internal_fast_osc_stable_flag, cpu_hold, take_irq_vector;
    logic                     watchdog_reset, watchdog_clear;
    int                       bad_count = 0;
    int                       cmp_count = 0;

    power_mode_sequencer #(
        .WAKE_PREP_CYCLES(WAKE),
        .INTERNAL_FAST_OSC_SETTLE_CYCLES(4)
    ) dut (
        .mclk, .rst, .osc_control_write, .osc_control_wdata, .osc_control_reg,
        .sleep_instr, .watchdog_clear_instr, .irq_flags, .irq_enables,
        .global_irq_enable, .watchdog_enable, .watchdog_timeout,
        .failsafe_enable(1'b0), .clock_lost(1'b0), .osc_ready, .cpu_clock_on,
        .periph_clock_on, .active_source, .primary_osc_on, .cpu_hold,
        .internal_fast_osc_on, .internal_slow_osc_on, .primary_ready_flag,
        .internal_fast_osc_stable_flag, .take_irq_vector, .watchdog_reset,
        .watchdog_clear, .mode);
    pms_partner cpu_side (.mclk, .rst, .irq_req, .wdt_req, .cpu_hold,
        .irq_flags, .watchdog_timeout);

    always #20 mclk = ~mclk;

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : step

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // A failed bounded wait leaves later steps meaningless, so stop.
    task automatic must(input logic [7:0] got, input logic [7:0] exp);
        chk(got, exp);
        if (got !== exp)
            report_and_stop();
    endtask : must

    task automatic write_ctrl(input logic i, input logic [2:0] f,
                              input logic [1:0] s);
        osc_control_wdata = '{i, f, 1'b0, s};
        osc_control_write = 1'b1;
        step(1);
        osc_control_write = 1'b0;
    endtask : write_ctrl

    task automatic do_sleep();
        sleep_instr = 1'b1;
        step(1);
        sleep_instr = 1'b0;
    endtask : do_sleep

    // Pulse a request; ends just after the edge where the sequencer sees it.
    task automatic fire(input logic [7:0] irq, input logic wdt);
        irq_req = irq;
        wdt_req = wdt;
        step(1);
        irq_req = 8'h00;
        wdt_req = 1'b0;
        step(1);
    endtask : fire

    task automatic t_startup();
        for (int i = 0; i < 20 && mode !== pms_pkg::ST_RUN; i++)
            step(1);
        must(mode, pms_pkg::ST_RUN);
        step(1);
        chk(primary_ready_flag, 8'h01);
        watchdog_clear_instr = 1'b1;
        step(1);
        watchdog_clear_instr = 1'b0;
        chk(watchdog_clear, 8'h01);
        $display("startup test done");
    endtask : t_startup

    task automatic t_idle_irq(input logic gie);
        global_irq_enable = gie;
        watchdog_enable = gie;
        irq_enables = 8'h04;
        write_ctrl(1'b1, 3'h0, 2'h0);
        do_sleep();
        chk(mode, pms_pkg::ST_IDLE);
        chk(watchdog_clear, 8'h01);
        chk(cpu_hold, 8'h01);
        step(1);
        chk(cpu_clock_on, 8'h00);
        chk(periph_clock_on, 8'h01);
        chk(internal_slow_osc_on, gie ? 8'h01 : 8'h00);
        fire(8'h02, 1'b0);
        chk(mode, pms_pkg::ST_IDLE);
        fire(8'h04, 1'b0);
        chk(mode, pms_pkg::ST_WAKE);
        step(WAKE);
        chk(mode, pms_pkg::ST_WAKE);
        step(1);
        chk(mode, pms_pkg::ST_RUN);
        chk(take_irq_vector, gie);
        chk(8'(osc_control_reg), 8'h40);
        $display("idle interrupt test done");
    endtask : t_idle_irq

    task automatic t_sleep_wdt();
        write_ctrl(1'b0, 3'h0, 2'h0);
        do_sleep();
        chk(mode, pms_pkg::ST_SLEEP);
        step(1);
        chk(periph_clock_on, 8'h00);
        chk(cpu_clock_on, 8'h00);
        fire(8'h00, 1'b1);
        chk(mode, pms_pkg::ST_WAKE);
        step(WAKE + 1);
        chk(mode, pms_pkg::ST_RUN);
        chk(take_irq_vector, 8'h00);
        $display("sleep watchdog test done");
    endtask : t_sleep_wdt

    task automatic t_source();
        write_ctrl(1'b0, 3'h0, 2'h1);
        step(4);
        chk(active_source, 8'h00);
        osc_ready = 3'h6;
        for (int i = 0; i < 20 && active_source !== 2'h1; i++)
            step(1);
        must(active_source, 8'h01);
        osc_ready = 3'h7;
        write_ctrl(1'b0, 3'h1, 2'h2);
        for (int i = 0; i < 20 && active_source !== 2'h2; i++)
            step(1);
        must(active_source, 8'h02);
        step(1);
        chk(primary_osc_on, 8'h00);
        chk(primary_ready_flag, 8'h00);
        chk(internal_fast_osc_on, 8'h01);
        for (int i = 0; i < 20 && internal_fast_osc_stable_flag !== 1'b1; i++)
            step(1);
        must(internal_fast_osc_stable_flag, 8'h01);
        write_ctrl(1'b1, 3'h1, 2'h2);
        do_sleep();
        step(2);
        chk(internal_fast_osc_stable_flag, 8'h01);
        chk(periph_clock_on, 8'h01);
        fire(8'h00, 1'b1);
        step(WAKE + 1);
        chk(mode, pms_pkg::ST_RUN);
        chk(active_source, 8'h02);
        chk(8'(osc_control_reg), 8'h4A);
        fire(8'h00, 1'b1);
        chk(watchdog_reset, 8'h01);
        $display("source test done");
    endtask : t_source

    initial
    begin
        step(2);
        rst = 1'b0;
        t_startup();
        t_idle_irq(1'b0);
        t_idle_irq(1'b1);
        t_sleep_wdt();
        t_source();
        report_and_stop();
    end
endmodule : test_power_mode_sequencer

bind power_mode_sequencer pms_monitor #(
    .WAKE_PREP_CYCLES(WAKE_PREP_CYCLES)
) mon (.mclk, .rst, .osc_control_write, .sleep_instr, .irq_flags,
    .irq_enables, .watchdog_enable, .watchdog_timeout, .osc_control_reg,
    .cpu_clock_on, .periph_clock_on, .internal_slow_osc_on, .watchdog_reset,
    .watchdog_clear, .mode);
